// >>> bench/gdfp_ctrl_model.sv
// controller model that answers bench requests with a clear command or an enable pulse
`timescale 1ns/1ps
module gdfp_ctrl_model (
  input  wire logic i_core_clk,
  input  wire logic i_req,
  input  wire logic i_use_pin,
  output logic      o_fault_clear_cmd = 1'b0,
  output logic      o_enable_reset_pulse = 1'b0
);
  // one-cycle clear, by command or by a valid enable high-low-high pulse
  always @(posedge i_core_clk) begin
    o_fault_clear_cmd    <= i_req && !i_use_pin;
    o_enable_reset_pulse <= i_req && i_use_pin;
  end
endmodule

// >>> bench/gdfp_fault_protect_asserts.sv
// assertions for the gate driver fault protection block
`timescale 1ns/1ps
module gdfp_fault_protect_asserts
  import gdfp_pkg::*;
(
  input wire logic         i_core_clk,
  input wire logic         i_reset,
  input wire gdfp_cfg_t    i_cfg,
  input wire gdfp_mon_t    i_mon,
  input wire logic         i_fault_clear_cmd,
  input wire logic         i_enable_reset_pulse,
  input wire logic         o_gate_hiz,
  input wire logic         o_pump_stop,
  input wire logic         o_logic_off,
  input wire logic         o_fault_indicator_low,
  input wire logic         o_fault_indicator_oe_n,
  input wire gdfp_status_t o_status
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire logic ds_hit = |(i_mon.ds_over & i_mon.fet_enabled);
  wire logic no_clr = !i_fault_clear_cmd && !i_enable_reset_pulse;
  wire logic raw    = !i_cfg.strap_variant;
  a_lockout_off: assert property (i_mon.supply_lockout |=> o_gate_hiz && o_pump_stop && o_logic_off
    && o_fault_indicator_low) else $error("lockout response missing");
  a_supply_flag: assert property (i_mon.supply_lockout |=> o_status.supply_low_flag && o_status.fault)
    else $error("supply flag not set");
  a_supply_hold: assert property (o_status.supply_low_flag && no_clr |=> o_status.supply_low_flag)
    else $error("supply flag lost without clear");
  a_pump_trip: assert property (i_mon.pump_low && (!raw || !i_cfg.pump_check_off) |=> o_gate_hiz
    && o_fault_indicator_low && o_status.pump_low_flag) else $error("pump low response missing");
  a_pump_quiet: assert property (i_mon.pump_low && raw && i_cfg.pump_check_off && !o_status.pump_low_flag
    |=> !o_status.pump_low_flag) else $error("pump check off still reports");
  a_gate_trip: assert property (i_mon.gate_stuck && !i_cfg.gate_check_off |=> o_gate_hiz
    && o_status.gate_stuck_fault) else $error("gate stuck response missing");
  a_gate_quiet: assert property (i_mon.gate_stuck && i_cfg.gate_check_off && !o_status.gate_stuck_fault
    |=> !o_status.gate_stuck_fault) else $error("gate check off still reports");
  a_heat_stop: assert property (i_mon.heat_hot |=> o_gate_hiz && o_pump_stop && o_status.heat_shutdown_flag)
    else $error("heat shutdown response missing");
  a_ds_deglitch: assert property ($rose(o_status.drain_source_overcurrent)
    |-> $past(ds_hit, 1) && $past(ds_hit, 2) && $past(ds_hit, 3)) else $error("overcurrent flagged too early");
  a_none_quiet: assert property (raw && i_cfg.overcurrent_policy == GDFP_POL_NONE
    && !o_status.drain_source_overcurrent |=> !o_status.drain_source_overcurrent) else $error("policy none reports");
  a_warn_track: assert property (i_mon.heat_warn |=> o_status.heat_warning_flag)
    else $error("heat warning flag not set");
  a_warn_report: assert property (i_mon.heat_warn && i_cfg.heat_warning_report |=> o_fault_indicator_low)
    else $error("heat warning not reported");
  a_pump_run: assert property (!i_mon.supply_lockout && !i_mon.heat_hot |=> !o_pump_stop)
    else $error("pump stopped without cause");
  a_oe_level: assert property (o_fault_indicator_oe_n == !o_fault_indicator_low)
    else $error("indicator enable not inverse of drive");
  c_supply: cover property (i_mon.supply_lockout);
  c_warn: cover property (i_mon.heat_warn && i_cfg.heat_warning_report);
  c_ds_trip: cover property ($rose(o_status.drain_source_overcurrent));
  c_clear: cover property (!no_clr && o_status.fault);
endmodule

bind gdfp_fault_protect gdfp_fault_protect_asserts u_asserts (.i_core_clk, .i_reset, .i_cfg, .i_mon,
  .i_fault_clear_cmd, .i_enable_reset_pulse, .o_gate_hiz, .o_pump_stop, .o_logic_off,
  .o_fault_indicator_low, .o_fault_indicator_oe_n, .o_status);

// >>> bench/gdfp_fault_protect_bench.sv
// self-checking bench for the gate driver fault protection block
`timescale 1ns/1ps
module gdfp_fault_protect_bench;
  import gdfp_pkg::*;
  logic         i_core_clk;
  logic         i_reset;
  logic         req;
  logic         use_pin;
  logic         clr;
  logic         pin_pulse;
  logic         gate_hiz;
  logic         pump_stop;
  logic         logic_off;
  logic         ind_low;
  logic         oe_n;
  gdfp_cfg_t    cfg;
  gdfp_mon_t    mon;
  gdfp_status_t st;
  logic [13:0]  exp_q[$];
  logic [13:0]  seen;
  logic [15:0]  lfsr = 16'h756f;
  logic [5:0]   f;
  int           error_cnt = 0;
  int           comparisons = 0;
  assign seen = {gate_hiz, logic_off, ind_low, st.fault, st.supply_low_flag, st.pump_low_flag,
                 st.drain_source_overcurrent, st.gate_stuck_fault, st.fet_oc_flags};
  gdfp_fault_protect u_dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_cfg(cfg), .i_mon(mon),
    .i_fault_clear_cmd(clr), .i_enable_reset_pulse(pin_pulse), .o_gate_hiz(gate_hiz), .o_pump_stop(pump_stop),
    .o_logic_off(logic_off), .o_fault_indicator_low(ind_low), .o_fault_indicator_oe_n(oe_n), .o_status(st));
  gdfp_ctrl_model u_ctrl (.i_core_clk(i_core_clk), .i_req(req), .i_use_pin(use_pin),
    .o_fault_clear_cmd(clr), .o_enable_reset_pulse(pin_pulse));
  // ****
  // helpers
  // ****
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic after(input int n, input logic [7:0] e, input logic [5:0] fe);
    wait_n(n);
    exp_q.push_back({e, fe});
  endtask
  task automatic clear(input logic pin);
    req     <= 1'b1;
    use_pin <= pin;
    @(posedge i_core_clk);
    req <= 1'b0;
    wait_n(2);
  endtask
  task automatic check(input logic [13:0] s, input logic [13:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("Error outputs expected %h seen %h", e, s);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(negedge i_core_clk) if (exp_q.size() > 0) check(seen, exp_q.pop_front());
  initial begin
    wait_n(4000);
    error_cnt++;
    end_sim();
  end
  // ****
  // scenarios
  // ****
  initial begin
    i_reset = 1'b1;
    req = 1'b0;
    use_pin = 1'b0;
    cfg = '0;
    cfg.ds_deg_cycles = 17'h00003;
    cfg.sh_deg_cycles = 17'h00003;
    cfg.retry_cycles = 17'h00014;
    mon = '0;
    mon.fet_enabled = 6'h3f;
    wait_n(16);
    i_reset <= 1'b0;
    wait_n(2);
    mon.supply_lockout <= 1'b1;
    after(2, 8'hf8, 6'h00);
    mon.supply_lockout <= 1'b0;
    after(2, 8'h18, 6'h00);
    clear(1'b0);
    after(0, 8'h00, 6'h00);
    mon.pump_low <= 1'b1;
    after(2, 8'hb4, 6'h00);
    mon.pump_low <= 1'b0;
    after(2, 8'h14, 6'h00);
    clear(1'b1);
    after(0, 8'h00, 6'h00);
    cfg.pump_check_off <= 1'b1;
    mon.pump_low <= 1'b1;
    after(2, 8'h00, 6'h00);
    mon.pump_low <= 1'b0;
    cfg.pump_check_off <= 1'b0;
    cfg.gate_check_off <= 1'b1;
    mon.gate_stuck <= 1'b1;
    after(2, 8'h00, 6'h00);
    cfg.gate_check_off <= 1'b0;
    after(2, 8'hb1, 6'h00);
    mon.gate_stuck <= 1'b0;
    after(2, 8'hb1, 6'h00);
    clear(1'b0);
    mon.heat_hot <= 1'b1;
    after(2, 8'hb0, 6'h00);
    mon.heat_hot <= 1'b0;
    clear(1'b0);
    after(0, 8'h00, 6'h00);
    cfg.heat_warning_report <= 1'b1;
    mon.heat_warn <= 1'b1;
    after(2, 8'h20, 6'h00);
    cfg.heat_warning_report <= 1'b0;
    after(2, 8'h00, 6'h00);
    mon.heat_warn <= 1'b0;
    cfg.shunt_check_off <= 1'b1;
    mon.shunt_over <= 3'h1;
    after(8, 8'h00, 6'h00);
    cfg.shunt_check_off <= 1'b0;
    after(8, 8'hb0, 6'h00);
    mon.shunt_over <= 3'h0;
    clear(1'b0);
    repeat (2) begin
      mon.ds_over <= 6'h01;
      wait_n(3);
      mon.ds_over <= 6'h00;
      wait_n(1);
    end
    after(2, 8'h00, 6'h00);
    for (int p = 0; p < 4; p++) begin
      cfg.overcurrent_policy <= gdfp_policy_t'(p);
      lfsr = lfsr_next(lfsr);
      f = lfsr[5:0] | 6'h01;
      mon.ds_over <= f;
      after(8, p == 3 ? 8'h00 : p == 2 ? 8'h32 : 8'hb2, p == 3 ? 6'h00 : f);
      mon.ds_over <= 6'h00;
      after(p == 1 ? 24 : 2, p[0] ? 8'h00 : p == 2 ? 8'h32 : 8'hb2, p[0] ? 6'h00 : f);
      clear(p[1]);
      after(0, 8'h00, 6'h00);
    end
    wait_n(3);
    end_sim();
  end
endmodule

// >>> logic/gdfp_cfg.svh
// timing constants and field layout for the gate driver fault protection block
`ifndef GDFP_CFG_SVH
`define GDFP_CFG_SVH

`define GDFP_CLK_HZ          20000000
// strapped drain-source deglitch 4.5 us, expressed in ns
`define GDFP_DS_DEG_NS       4500
// strapped shunt deglitch 4 us, expressed in ns
`define GDFP_SH_DEG_NS       4000
// retry interval 4 ms, expressed in us
`define GDFP_RETRY_US        4000
// least times round up to whole cycles
`define GDFP_DS_DEG_CYC      ((`GDFP_DS_DEG_NS * (`GDFP_CLK_HZ / 1000000) + 999) / 1000)
`define GDFP_SH_DEG_CYC      ((`GDFP_SH_DEG_NS * (`GDFP_CLK_HZ / 1000000) + 999) / 1000)
`define GDFP_RETRY_CYC       (`GDFP_RETRY_US * (`GDFP_CLK_HZ / 1000000))
`define GDFP_CNT_W           17
`define GDFP_FETS            6
`define GDFP_PHASES          3

`endif

// >>> logic/gdfp_fault_protect.sv
// fault supervision and response logic for a three-phase gate driver
// Behaviour
// - supply undervoltage: bridge Hi-Z, pump stopped, logic off, indicator low.
// - supply undervoltage latches summary and supply-low flag; flag held until cleared.
// - pump undervoltage: gates off, indicator low, flags latched; flag held until cleared.
// - pump-check disable bit suppresses pump protection and its report.
// - drain-source overcurrent only on enabled fet beyond deglitch time; policy applies.
// - strapped: fixed 4.5 us deglitch, 4 ms retry, threshold pin at logic rail disables.
// - policy 00b: Hi-Z, indicator low, flags latched until condition gone and clear.
// - policy 01b: gates off, indicator low, flags held until retry interval ends.
// - policy 10b: report only, cleared once condition gone and clear arrives.
// - policy 11b: no action, no report.
// - shunt overcurrent when sense input above threshold beyond deglitch time.
// - strapped shunt: fixed 1 V threshold, 4 us deglitch, 4 ms retry.
// - shunt follows same policy, but 00b leaves shunt_flags clear; shunt-check disable gives no action unless strapped.
// - gate stuck fault: Hi-Z, indicator low, latched; none when check is off.
// - strapped variant keeps pump protection permanently on.
// - heat warning flag auto clears; reports on indicator only when enabled.
// - heat shutdown: Hi-Z, pump off, indicator low; flag latched until clear.
`timescale 1ns/1ps

module gdfp_fault_protect
  import gdfp_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_reset,
  input  wire gdfp_cfg_t    i_cfg,
  input  wire gdfp_mon_t    i_mon,
  input  wire logic         i_fault_clear_cmd,
  input  wire logic         i_enable_reset_pulse,
  output logic              o_gate_hiz,
  output logic              o_pump_stop,
  output logic              o_logic_off,
  output logic              o_fault_indicator_low,
  output logic              o_fault_indicator_oe_n,
  output gdfp_status_t      o_status
);

  // ****************************************
  // timing selection
  // ****************************************
  localparam logic [`GDFP_CNT_W-1:0] DS_DEG_STRAP = `GDFP_CNT_W'(`GDFP_DS_DEG_CYC);
  localparam logic [`GDFP_CNT_W-1:0] SH_DEG_STRAP = `GDFP_CNT_W'(`GDFP_SH_DEG_CYC);
  localparam logic [`GDFP_CNT_W-1:0] RETRY_STRAP  = `GDFP_CNT_W'(`GDFP_RETRY_CYC);

  gdfp_state_t  state_reg;
  gdfp_state_t  state_next;
  gdfp_policy_t policy;
  logic         clear;
  logic         ds_cond;
  logic         sh_cond;
  logic         ds_on;
  logic         sh_on;
  logic         pump_on;
  logic [`GDFP_CNT_W-1:0] ds_deg;
  logic [`GDFP_CNT_W-1:0] sh_deg;
  logic [`GDFP_CNT_W-1:0] retry;

  // one overcurrent channel: deglitch, then policy response
  function automatic gdfp_oc_t oc_step(input gdfp_oc_t cur, input logic cond, input logic en,
                                       input gdfp_policy_t pol, input logic clr,
                                       input logic [`GDFP_CNT_W-1:0] deg,
                                       input logic [`GDFP_CNT_W-1:0] rty);
    gdfp_oc_t n;
    n = cur;
    n.flagged = 1'b0;
    case (cur.st)
      GDFP_OC_IDLE: begin
        if (!en || !cond) begin
          n.cnt = '0;
        end else if (cur.cnt >= deg) begin
          n.cnt     = '0;
          n.flagged = 1'b1;
          n.st      = (pol == GDFP_POL_RETRY) ? GDFP_OC_RETRY : GDFP_OC_HOLD;
        end else begin
          n.cnt = cur.cnt + `GDFP_CNT_W'(1);
        end
      end
      GDFP_OC_HOLD: begin
        if (!cond && clr) begin
          n.st = GDFP_OC_IDLE;
        end
      end
      GDFP_OC_RETRY: begin
        if (cur.cnt >= rty) begin
          n.cnt = '0;
          n.st  = GDFP_OC_IDLE;
        end else begin
          n.cnt = cur.cnt + `GDFP_CNT_W'(1);
        end
      end
      default: begin
        n.cnt = '0;
        n.st  = GDFP_OC_IDLE;
      end
    endcase
    return n;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    clear   = i_fault_clear_cmd | i_enable_reset_pulse;
    policy  = i_cfg.strap_variant ? GDFP_POL_RETRY : i_cfg.overcurrent_policy;
    ds_deg  = i_cfg.strap_variant ? DS_DEG_STRAP : i_cfg.ds_deg_cycles;
    sh_deg  = i_cfg.strap_variant ? SH_DEG_STRAP : i_cfg.sh_deg_cycles;
    retry   = i_cfg.strap_variant ? RETRY_STRAP : i_cfg.retry_cycles;
    ds_cond = |(i_mon.ds_over & i_mon.fet_enabled);
    sh_cond = |i_mon.shunt_over;
    ds_on   = (policy != GDFP_POL_NONE) && !(i_cfg.strap_variant && i_cfg.drain_threshold_pin);
    sh_on   = (policy != GDFP_POL_NONE) && (i_cfg.strap_variant || !i_cfg.shunt_check_off);
    pump_on = i_cfg.strap_variant || !i_cfg.pump_check_off;

    state_next    = state_reg;
    state_next.ds = oc_step(state_reg.ds, ds_cond, ds_on, policy, clear, ds_deg, retry);
    state_next.sh = oc_step(state_reg.sh, sh_cond, sh_on, policy, clear, sh_deg, retry);

    // sticky flags: clear first, then sets win
    if (clear) begin
      state_next.status.supply_low_flag    = 1'b0;
      state_next.status.pump_low_flag      = 1'b0;
      state_next.status.heat_shutdown_flag = 1'b0;
      if (!i_mon.gate_stuck) begin
        state_next.status.gate_stuck_fault = 1'b0;
      end
    end
    if (i_mon.supply_lockout) begin
      state_next.status.supply_low_flag = 1'b1;
    end
    if (i_mon.pump_low && pump_on) begin
      state_next.status.pump_low_flag = 1'b1;
    end
    if (i_mon.gate_stuck && !i_cfg.gate_check_off) begin
      state_next.status.gate_stuck_fault = 1'b1;
    end
    if (i_mon.heat_hot) begin
      state_next.status.heat_shutdown_flag = 1'b1;
    end
    state_next.status.heat_warning_flag = i_mon.heat_warn;

    // overcurrent flags track their channel until released
    if (state_next.ds.st == GDFP_OC_IDLE) begin
      state_next.status.drain_source_overcurrent = 1'b0;
      state_next.status.fet_oc_flags             = '0;
    end
    if (state_next.ds.flagged) begin
      state_next.status.drain_source_overcurrent = 1'b1;
      state_next.status.fet_oc_flags             = i_mon.ds_over & i_mon.fet_enabled;
    end
    if (state_next.sh.st == GDFP_OC_IDLE) begin
      state_next.status.shunt_overcurrent = 1'b0;
      state_next.status.shunt_flags       = '0;
    end
    if (state_next.sh.flagged) begin
      state_next.status.shunt_overcurrent = 1'b1;
      if (policy != GDFP_POL_LATCH) begin
        state_next.status.shunt_flags = i_mon.shunt_over;
      end
    end

    state_next.status.fault = state_next.status.supply_low_flag | state_next.status.pump_low_flag
                            | state_next.status.drain_source_overcurrent
                            | state_next.status.shunt_overcurrent | state_next.status.gate_stuck_fault
                            | state_next.status.heat_shutdown_flag;

    state_next.logic_off = i_mon.supply_lockout;
    state_next.pump_stop = i_mon.supply_lockout | i_mon.heat_hot;
    state_next.gate_hiz  = i_mon.supply_lockout | (i_mon.pump_low & pump_on) | i_mon.heat_hot
                         | state_next.status.gate_stuck_fault
                         | ((state_next.ds.st != GDFP_OC_IDLE) && (policy != GDFP_POL_REPORT))
                         | ((state_next.sh.st != GDFP_OC_IDLE) && (policy != GDFP_POL_REPORT));
    state_next.fault_indicator_low = i_mon.supply_lockout | (i_mon.pump_low & pump_on) | i_mon.heat_hot
                                   | state_next.status.gate_stuck_fault
                                   | (state_next.ds.st != GDFP_OC_IDLE) | (state_next.sh.st != GDFP_OC_IDLE)
                                   | (i_mon.heat_warn & i_cfg.heat_warning_report);
    // open-drain enable is low while the pin is pulled low
    state_next.fault_indicator_oe_n = ~state_next.fault_indicator_low;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg       <= '0;
      state_reg.ds.st <= GDFP_OC_IDLE;
      state_reg.sh.st <= GDFP_OC_IDLE;
      state_reg.fault_indicator_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_gate_hiz             = state_reg.gate_hiz;
  assign o_pump_stop            = state_reg.pump_stop;
  assign o_logic_off            = state_reg.logic_off;
  assign o_fault_indicator_low  = state_reg.fault_indicator_low;
  assign o_fault_indicator_oe_n = state_reg.fault_indicator_oe_n;
  assign o_status               = state_reg.status;

endmodule

// >>> logic/gdfp_pkg.sv
// types for the gate driver fault protection block
`include "gdfp_cfg.svh"

package gdfp_pkg;

  typedef enum logic [1:0] {
    GDFP_POL_LATCH  = 2'h0,
    GDFP_POL_RETRY  = 2'h1,
    GDFP_POL_REPORT = 2'h2,
    GDFP_POL_NONE   = 2'h3
  } gdfp_policy_t;

  typedef enum logic [2:0] {
    GDFP_OC_IDLE  = 3'h1,
    GDFP_OC_HOLD  = 3'h2,
    GDFP_OC_RETRY = 3'h4
  } gdfp_oc_state_t;

  // configuration inputs
  typedef struct packed {
    logic         strap_variant;
    gdfp_policy_t overcurrent_policy;
    logic         pump_check_off;
    logic         shunt_check_off;
    logic         gate_check_off;
    logic         heat_warning_report;
    logic         drain_threshold_pin;
    logic [`GDFP_CNT_W-1:0] ds_deg_cycles;
    logic [`GDFP_CNT_W-1:0] sh_deg_cycles;
    logic [`GDFP_CNT_W-1:0] retry_cycles;
  } gdfp_cfg_t;

  // analog comparator and monitor inputs
  typedef struct packed {
    logic                    supply_lockout;
    logic                    pump_low;
    logic [`GDFP_FETS-1:0]   fet_enabled;
    logic [`GDFP_FETS-1:0]   ds_over;
    logic [`GDFP_PHASES-1:0] shunt_over;
    logic                    gate_stuck;
    logic                    heat_warn;
    logic                    heat_hot;
  } gdfp_mon_t;

  // status flags, latched except heat_warning_flag and the overcurrent flags under policy 01b, which clear when retry ends
  typedef struct packed {
    logic                    fault;
    logic                    supply_low_flag;
    logic                    pump_low_flag;
    logic                    drain_source_overcurrent;
    logic [`GDFP_FETS-1:0]   fet_oc_flags;
    logic                    shunt_overcurrent;
    logic [`GDFP_PHASES-1:0] shunt_flags;
    logic                    gate_stuck_fault;
    logic                    heat_warning_flag;
    logic                    heat_shutdown_flag;
  } gdfp_status_t;

  typedef struct packed {
    logic [`GDFP_CNT_W-1:0] cnt;
    gdfp_oc_state_t         st;
    logic                   flagged;
  } gdfp_oc_t;

  typedef struct packed {
    gdfp_oc_t     ds;
    gdfp_oc_t     sh;
    gdfp_status_t status;
    logic         gate_hiz;
    logic         pump_stop;
    logic         logic_off;
    logic         fault_indicator_low;
    logic         fault_indicator_oe_n;
  } gdfp_state_t;

endpackage
